// ---- verilog/histo_cmd_pkg.sv ----
// constants for the monitoring and histogram command interpreter
package histo_cmd_pkg;
    // ************************************************************
    // memory map: pages and byte addresses
    // ************************************************************
    localparam logic [7:0] PAGE_STATUS = 8'h00;
    localparam logic [7:0] PAGE_CMD = 8'h9f;
    localparam logic [7:0] OFF_CODE_HI = 8'h80;
    localparam logic [7:0] OFF_CODE_LO = 8'h81;
    localparam logic [7:0] OFF_XLEN_HI = 8'h82;
    localparam logic [7:0] OFF_XLEN_LO = 8'h83;
    localparam logic [7:0] OFF_PLEN = 8'h84;
    localparam logic [7:0] OFF_CHK = 8'h85;
    localparam logic [7:0] OFF_RLEN = 8'h86;
    localparam logic [7:0] OFF_RCHK = 8'h87;
    localparam logic [7:0] OFF_PAYLOAD = 8'h88;
    localparam logic [7:0] OFF_FLAG_BYTE = 8'h08;
    localparam int DONE_BIT = 6;
    localparam logic [7:0] OFF_RESULT = 8'h25;
    // ************************************************************
    // command codes and field values
    // ************************************************************
    localparam logic [15:0] CMD_ADVERT = 16'h0281;
    localparam logic [15:0] CMD_HISTO = 16'h0290;
    localparam logic [15:0] XLEN_NONE = 16'h0000;
    localparam logic [7:0] ADVERT_PLEN = 8'h00;
    localparam logic [7:0] HISTO_PLEN = 8'h01;
    localparam int SUB_SAVE_BIT = 1;
    localparam int SUB_RETURN_BIT = 2;
    localparam int SUB_CLEAR_BIT = 7;
    localparam logic [7:0] REPLY_LEN_NONE = 8'h00;
    localparam logic [7:0] REPLY_LEN_ECHO = 8'h01;
    localparam logic [7:0] REPLY_LEN_FULL = 8'h34;
    localparam logic [7:0] REPLY_IDX_HOURS = 8'h01;
    localparam logic [7:0] REPLY_IDX_TOTAL = 8'h04;
    localparam logic [7:0] REPLY_IDX_BINS = 8'h08;
    // ************************************************************
    // result codes
    // ************************************************************
    localparam logic [7:0] RES_NONE = 8'h00;
    localparam logic [7:0] RES_CAPTURED = 8'h81;
    localparam logic [7:0] RES_CHECKING = 8'h82;
    localparam logic [7:0] RES_EXECUTING = 8'h83;
    localparam logic [7:0] RES_OK = 8'h01;
    localparam logic [7:0] RES_FAIL = 8'h40;
    localparam logic [7:0] RES_PARAM = 8'h42;
    localparam logic [7:0] RES_CHKERR = 8'h45;
    // ************************************************************
    // histogram bins and time base
    // ************************************************************
    localparam int NUM_BINS = 11;
    localparam int SEL_W = 4;
    localparam int BIN_WIDTH_DEGC = 10;
    localparam int BIN_LOW_EDGE_DEGC = -5;
    localparam int CLOCK_HZ = 50_000_000;
    localparam int SAMPLE_PERIOD_S = 1;
    localparam int SAMPLE_CYCLES = CLOCK_HZ * SAMPLE_PERIOD_S;
    localparam int PERSIST_PERIOD_S = 3600;
    localparam int PERSIST_TICKS = PERSIST_PERIOD_S / SAMPLE_PERIOD_S;
    localparam logic [7:0] PERSIST_HOURS = 8'(PERSIST_PERIOD_S / 3600);
endpackage

// ---- verilog/histo_if.sv ----
// link between the command interpreter and the histogram accumulator
`timescale 1ns/1ps
`default_nettype none
interface histo_if;
    logic save; // copy live histogram to persistent store
    logic clear; // zero live histogram and persistent store
    logic snap; // freeze live histogram for the reply
    logic [histo_cmd_pkg::SEL_W-1:0] sel; // bin to read
    logic [31:0] word; // seconds in the selected frozen bin
    logic [31:0] total; // frozen total seconds
    modport ctl (output save, clear, snap, sel, input word, total);
    modport acc (input save, clear, snap, sel, output word, total);
endinterface
`default_nettype wire

// ---- verilog/histo_accum.sv ----
// temperature histogram accumulator with persistent store model
`timescale 1ns/1ps
`default_nettype none
module histo_accum #(
    parameter int NUM_BINS = histo_cmd_pkg::NUM_BINS,
    parameter int TICK_CYCLES = histo_cmd_pkg::SAMPLE_CYCLES,
    parameter int PERSIST_TICKS = histo_cmd_pkg::PERSIST_TICKS
) (
    input wire logic clock_in, // system clock
    input wire logic rstn_in, // synchronous reset, active low
    input wire logic [7:0] temp_in, // signed temperature in degC
    histo_if.acc hif // commands from the interpreter
);
    typedef struct packed {
        logic [31:0] tick;
        logic [31:0] persist;
        logic [NUM_BINS-1:0][31:0] live;
        logic [NUM_BINS-1:0][31:0] store;
        logic [NUM_BINS-1:0][31:0] snap;
        logic [31:0] live_total;
        logic [31:0] store_total;
        logic [31:0] snap_total;
    } acc_t;
    acc_t s_ff;
    acc_t nxt_s;
    logic second;
    logic [histo_cmd_pkg::SEL_W-1:0] bin;
    // ************************************************************
    // sampling, binning and commit
    // ************************************************************
    // bins are 10 degC wide; first bin is everything below the low edge, last bin everything from 85 degC up
    always_comb begin
        int tv;
        int bi;
        tv = int'($signed(temp_in));
        bi = 0;
        nxt_s = s_ff;
        second = (s_ff.tick == 32'(TICK_CYCLES - 1));
        nxt_s.tick = second ? 32'h0 : s_ff.tick + 32'h1;
        if (tv >= histo_cmd_pkg::BIN_LOW_EDGE_DEGC) begin
            bi = (tv - histo_cmd_pkg::BIN_LOW_EDGE_DEGC)
                / histo_cmd_pkg::BIN_WIDTH_DEGC + 1;
        end
        if (bi > NUM_BINS - 1) begin
            bi = NUM_BINS - 1;
        end
        bin = histo_cmd_pkg::SEL_W'(bi);
        if (second) begin
            nxt_s.live[bin] = s_ff.live[bin] + 32'h1;
            nxt_s.live_total = s_ff.live_total + 32'h1;
            nxt_s.persist = s_ff.persist + 32'h1;
        end
        // autonomous commit at a period of our own choosing
        if (second && s_ff.persist == 32'(PERSIST_TICKS - 1)) begin
            nxt_s.persist = 32'h0;
            nxt_s.store = nxt_s.live;
            nxt_s.store_total = nxt_s.live_total;
        end
        // clear acts before save and snap so both see zeros
        if (hif.clear) begin
            nxt_s.live = '0;
            nxt_s.live_total = 32'h0;
            nxt_s.store = '0;
            nxt_s.store_total = 32'h0;
        end
        if (hif.save) begin
            nxt_s.store = nxt_s.live;
            nxt_s.store_total = nxt_s.live_total;
            nxt_s.persist = 32'h0;
        end
        if (hif.snap) begin
            nxt_s.snap = nxt_s.live;
            nxt_s.snap_total = nxt_s.live_total;
        end
    end

    // the persistent store only resets because nothing models power loss
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // frozen words for the reply walk and for host reads
    assign hif.word = s_ff.snap[hif.sel];
    assign hif.total = s_ff.snap_total;

    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    a_second_counts: assert property (second && !hif.clear |=>
        s_ff.live_total == $past(s_ff.live_total) + 32'h1)
        else $error("one second not added to total");
    a_clear_zero: assert property (hif.clear |=>
        s_ff.store_total == 32'h0 && s_ff.live_total == 32'h0
        && (!$past(hif.snap) || s_ff.snap_total == 32'h0))
        else $error("clear left counts in the store");
    a_save_copy: assert property (hif.save && !hif.clear
        && !second |=> s_ff.store == $past(s_ff.live))
        else $error("save did not copy the live histogram");
endmodule
`default_nettype wire

// ---- verilog/histo_cmd_top.sv ----
// command interpreter for the advertisement and histogram messages
//
// Overview of operation
// - code 0281h: empty advertisement, no payload, answered with success
// - check byte is inverted sum of header bytes 128-132 and the first payload byte
// - completion flag goes to one when a command has finished
// - result byte: 01h success, 40h failure without specific cause
// - bad or unsupported parameter ends the command with 42h
// - check byte mismatch ends the command with 45h
// - seconds per temperature bin accumulate and persist until cleared
// - sampling and commit intervals are ours; time base accuracy open
// - sub-command bit 1 copies the live histogram to the store
// - sub-command bit 2 returns seconds per 10 degC bin
// - sub-command bit 7 clears all counts, store included
// - busy codes 81h, 82h, 83h mark capture, checking and execution
// - first reply byte echoes the sub-command byte
// - reply byte two gives the fixed persistent write period in hours
// - reply holds 32-bit total seconds then 32-bit bin counts
`timescale 1ns/1ps
`default_nettype none
module histo_cmd_top #(
    parameter int TICK_CYCLES = histo_cmd_pkg::SAMPLE_CYCLES,
    parameter int PERSIST_TICKS = histo_cmd_pkg::PERSIST_TICKS
) (
    input wire logic clock_in, // 50 MHz system clock
    input wire logic rstn_in, // synchronous reset, active low
    input wire logic [7:0] temp_in, // signed module temperature, degC
    input wire logic [7:0] mem_page_in, // selected page
    input wire logic [7:0] mem_addr_in, // byte address in page
    input wire logic mem_wr_in, // byte write strobe
    input wire logic mem_rd_in, // byte read strobe
    input wire logic [7:0] mem_wdata_in, // write data
    output logic [7:0] mem_rdata_out, // read data, one cycle after strobe
    output logic busy_out // command in progress
);
    typedef enum logic [2:0] {
        IDLE, CAPTURED, CHECKING, EXECUTING, REPLYING
    } phase_t;
    typedef struct packed {
        phase_t phase;
        logic [15:0] code;
        logic [15:0] xlen;
        logic [7:0] plen;
        logic [7:0] chk;
        logic [7:0] rlen;
        logic [7:0] rchk;
        logic [7:0] sub;
        logic [7:0] result;
        logic done;
        logic [7:0] rdata;
        logic [7:0] walk;
        logic [7:0] sum;
        logic save;
        logic clear;
        logic snap;
    } cmd_t;
    cmd_t s_ff;
    cmd_t nxt_s;
    histo_if hif ();
    logic page_cmd;
    logic page_status;
    logic trigger;
    logic [7:0] calc_sum;
    logic chk_ok;
    logic param_ok;
    logic [7:0] idx;
    logic [7:0] rel;
    logic [7:0] rbyte;

    // ************************************************************
    // histogram accumulator
    // ************************************************************
    histo_accum #(
        .NUM_BINS(histo_cmd_pkg::NUM_BINS),
        .TICK_CYCLES(TICK_CYCLES),
        .PERSIST_TICKS(PERSIST_TICKS)
    ) u_accum (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .temp_in(temp_in),
        .hif(hif.acc)
    );

    // ************************************************************
    // header checks
    // ************************************************************
    // payload beyond the first byte is never stored, so it is not summed
    always_comb begin
        calc_sum = s_ff.code[15:8] + s_ff.code[7:0] + s_ff.xlen[15:8]
            + s_ff.xlen[7:0] + s_ff.plen;
        if (s_ff.plen != histo_cmd_pkg::ADVERT_PLEN) begin
            calc_sum = calc_sum + s_ff.sub;
        end
        chk_ok = (~calc_sum == s_ff.chk);
    end

    // only the two known codes with their exact lengths are accepted
    always_comb begin
        param_ok = 1'b0;
        if (s_ff.xlen == histo_cmd_pkg::XLEN_NONE) begin
            if (s_ff.code == histo_cmd_pkg::CMD_ADVERT) begin
                param_ok = (s_ff.plen == histo_cmd_pkg::ADVERT_PLEN);
            end else if (s_ff.code == histo_cmd_pkg::CMD_HISTO) begin
                param_ok = (s_ff.plen == histo_cmd_pkg::HISTO_PLEN);
            end
        end
    end

    // ************************************************************
    // reply byte selection
    // ************************************************************
    // one index feeds both the reply walk and host reads; host reads of
    // the reply area return zero while the walk owns the index, or the sub-command byte while the walk is at byte 0
    always_comb begin
        idx = (s_ff.phase == REPLYING) ? s_ff.walk
            : mem_addr_in - histo_cmd_pkg::OFF_PAYLOAD;
        rel = idx - histo_cmd_pkg::REPLY_IDX_BINS;
        hif.sel = rel[histo_cmd_pkg::SEL_W+1:2];
        rbyte = 8'h00;
        if (idx == 8'h00) begin
            rbyte = s_ff.sub;
        end else if (idx == histo_cmd_pkg::REPLY_IDX_HOURS) begin
            rbyte = histo_cmd_pkg::PERSIST_HOURS;
        end else if (idx >= histo_cmd_pkg::REPLY_IDX_TOTAL
            && idx < histo_cmd_pkg::REPLY_IDX_BINS) begin
            rbyte = hif.total[8*(3-idx[1:0]) +: 8];
        end else if (idx >= histo_cmd_pkg::REPLY_IDX_BINS
            && idx < histo_cmd_pkg::REPLY_LEN_FULL) begin
            rbyte = hif.word[8*(3-idx[1:0]) +: 8];
        end
    end

    assign page_cmd = (mem_page_in == histo_cmd_pkg::PAGE_CMD);
    assign page_status = (mem_page_in == histo_cmd_pkg::PAGE_STATUS);
    assign trigger = mem_wr_in && page_cmd && s_ff.phase == IDLE
        && mem_addr_in == histo_cmd_pkg::OFF_CODE_LO;

    // ************************************************************
    // register access and command sequencing
    // ************************************************************
    always_comb begin
        nxt_s = s_ff;
        nxt_s.save = 1'b0;
        nxt_s.clear = 1'b0;
        nxt_s.snap = 1'b0;
        // host reads; the flag byte clears on read
        if (mem_rd_in) begin
            nxt_s.rdata = 8'h00;
            if (page_status && mem_addr_in == histo_cmd_pkg::OFF_FLAG_BYTE)
            begin
                nxt_s.rdata[histo_cmd_pkg::DONE_BIT] = s_ff.done;
                nxt_s.done = 1'b0;
            end else if (page_status
                && mem_addr_in == histo_cmd_pkg::OFF_RESULT) begin
                nxt_s.rdata = s_ff.result;
            end else if (page_cmd) begin
                unique case (mem_addr_in)
                    histo_cmd_pkg::OFF_CODE_HI: nxt_s.rdata = s_ff.code[15:8];
                    histo_cmd_pkg::OFF_CODE_LO: nxt_s.rdata = s_ff.code[7:0];
                    histo_cmd_pkg::OFF_XLEN_HI: nxt_s.rdata = s_ff.xlen[15:8];
                    histo_cmd_pkg::OFF_XLEN_LO: nxt_s.rdata = s_ff.xlen[7:0];
                    histo_cmd_pkg::OFF_PLEN: nxt_s.rdata = s_ff.plen;
                    histo_cmd_pkg::OFF_CHK: nxt_s.rdata = s_ff.chk;
                    histo_cmd_pkg::OFF_RLEN: nxt_s.rdata = s_ff.rlen;
                    histo_cmd_pkg::OFF_RCHK: nxt_s.rdata = s_ff.rchk;
                    default: begin
                        if (idx < s_ff.rlen && s_ff.phase != REPLYING) begin
                            nxt_s.rdata = rbyte;
                        end else if (idx == 8'h00) begin
                            nxt_s.rdata = s_ff.sub;
                        end
                    end
                endcase
            end
        end
        // host writes land only while no command runs
        if (mem_wr_in && page_cmd && s_ff.phase == IDLE) begin
            unique case (mem_addr_in)
                histo_cmd_pkg::OFF_CODE_HI: nxt_s.code[15:8] = mem_wdata_in;
                histo_cmd_pkg::OFF_CODE_LO: nxt_s.code[7:0] = mem_wdata_in;
                histo_cmd_pkg::OFF_XLEN_HI: nxt_s.xlen[15:8] = mem_wdata_in;
                histo_cmd_pkg::OFF_XLEN_LO: nxt_s.xlen[7:0] = mem_wdata_in;
                histo_cmd_pkg::OFF_PLEN: nxt_s.plen = mem_wdata_in;
                histo_cmd_pkg::OFF_CHK: nxt_s.chk = mem_wdata_in;
                histo_cmd_pkg::OFF_RLEN: nxt_s.rlen = mem_wdata_in;
                histo_cmd_pkg::OFF_RCHK: nxt_s.rchk = mem_wdata_in;
                histo_cmd_pkg::OFF_PAYLOAD: nxt_s.sub = mem_wdata_in;
                default: ; // bytes past the payload are ignored
            endcase
        end
        unique case (s_ff.phase)
            IDLE: begin
                if (trigger) begin
                    nxt_s.phase = CAPTURED;
                    nxt_s.result = histo_cmd_pkg::RES_CAPTURED;
                end
            end
            CAPTURED: begin
                nxt_s.phase = CHECKING;
                nxt_s.result = histo_cmd_pkg::RES_CHECKING;
            end
            CHECKING: begin
                nxt_s.phase = IDLE;
                if (!chk_ok) begin
                    nxt_s.result = histo_cmd_pkg::RES_CHKERR;
                    nxt_s.done = 1'b1;
                end else if (!param_ok) begin
                    nxt_s.result = histo_cmd_pkg::RES_PARAM;
                    nxt_s.done = 1'b1;
                end else if (s_ff.code == histo_cmd_pkg::CMD_ADVERT) begin
                    // nothing to advertise yet: empty reply
                    nxt_s.rlen = histo_cmd_pkg::REPLY_LEN_NONE;
                    nxt_s.rchk = ~histo_cmd_pkg::REPLY_LEN_NONE;
                    nxt_s.result = histo_cmd_pkg::RES_OK;
                    nxt_s.done = 1'b1;
                end else begin
                    nxt_s.phase = EXECUTING;
                    nxt_s.result = histo_cmd_pkg::RES_EXECUTING;
                    nxt_s.save = s_ff.sub[histo_cmd_pkg::SUB_SAVE_BIT];
                    nxt_s.clear =
                        s_ff.sub[histo_cmd_pkg::SUB_CLEAR_BIT];
                    nxt_s.snap = 1'b1;
                end
            end
            EXECUTING: begin
                // the snapshot taken at this edge is read from next cycle
                nxt_s.phase = REPLYING;
                nxt_s.walk = 8'h00;
                nxt_s.sum = 8'h00;
                nxt_s.rlen = s_ff.sub[histo_cmd_pkg::SUB_RETURN_BIT]
                    ? histo_cmd_pkg::REPLY_LEN_FULL
                    : histo_cmd_pkg::REPLY_LEN_ECHO;
            end
            REPLYING: begin
                nxt_s.sum = s_ff.sum + rbyte;
                nxt_s.walk = s_ff.walk + 8'h01;
                if (s_ff.walk == s_ff.rlen - 8'h01) begin
                    nxt_s.phase = IDLE;
                    nxt_s.rchk = ~(s_ff.sum + rbyte);
                    nxt_s.result = histo_cmd_pkg::RES_OK;
                    nxt_s.done = 1'b1;
                end
            end
        endcase
    end

    // state register; the set of the flag is placed after its clear
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign hif.save = s_ff.save;
    assign hif.clear = s_ff.clear;
    assign hif.snap = s_ff.snap;
    assign mem_rdata_out = s_ff.rdata;
    assign busy_out = (s_ff.phase != IDLE);

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    sequence busy_start;
        s_ff.phase == CAPTURED
            && s_ff.result == histo_cmd_pkg::RES_CAPTURED;
    endsequence
    sequence busy_check;
        s_ff.phase == CHECKING
            && s_ff.result == histo_cmd_pkg::RES_CHECKING;
    endsequence
    a_busy_codes: assert property (trigger |=>
        busy_start ##1 busy_check)
        else $error("busy codes out of order");
    a_check_error: assert property (s_ff.phase == CHECKING
        && !chk_ok
        |=> s_ff.result == histo_cmd_pkg::RES_CHKERR && s_ff.done)
        else $error("check mismatch not reported");
    a_param_error: assert property (s_ff.phase == CHECKING
        && chk_ok && !param_ok
        |=> s_ff.result == histo_cmd_pkg::RES_PARAM && s_ff.done)
        else $error("parameter error not reported");
    a_advert_done: assert property (s_ff.phase == CHECKING
        && chk_ok && param_ok && s_ff.code == histo_cmd_pkg::CMD_ADVERT
        |=> s_ff.result == histo_cmd_pkg::RES_OK
            && s_ff.rlen == histo_cmd_pkg::REPLY_LEN_NONE)
        else $error("advertisement not answered");
    a_done_ends: assert property ($rose(s_ff.done)
        |-> s_ff.phase == IDLE && $past(s_ff.phase) != IDLE)
        else $error("flag set outside a finish");
    a_histo_finish: assert property (s_ff.phase == EXECUTING
        |-> ##[1:60] s_ff.phase == IDLE
            && s_ff.result == histo_cmd_pkg::RES_OK)
        else $error("histogram command never finished");
    a_return_len: assert property (s_ff.phase == EXECUTING
        && s_ff.sub[histo_cmd_pkg::SUB_RETURN_BIT]
        |=> s_ff.rlen == histo_cmd_pkg::REPLY_LEN_FULL)
        else $error("full reply length not set");
    a_sub_strobes: assert property (s_ff.phase == EXECUTING
        |-> s_ff.save == s_ff.sub[histo_cmd_pkg::SUB_SAVE_BIT]
            && s_ff.clear == s_ff.sub[histo_cmd_pkg::SUB_CLEAR_BIT])
        else $error("sub-command strobes do not match");
    a_echo_hours: assert property (s_ff.phase == REPLYING
        && s_ff.walk == histo_cmd_pkg::REPLY_IDX_HOURS
        |-> rbyte == histo_cmd_pkg::PERSIST_HOURS
            && $past(rbyte) == s_ff.sub)
        else $error("echo or hours byte wrong");
endmodule
`default_nettype wire

// ---- tb/host_model.sv ----
// host model that writes command messages over the byte bus
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clock_in, // system clock
    output logic [7:0] page_out, // page select
    output logic [7:0] addr_out, // byte address
    output logic wr_out, // write strobe
    output logic rd_out, // read strobe
    output logic [7:0] wdata_out, // write data
    input wire logic [7:0] rdata_in // read data
);
    initial {page_out, addr_out, wr_out, rd_out, wdata_out} = 26'h0;
    // one strobe cycle per byte; released data is inverted, not left stale
    task automatic acc(input logic w, input logic [7:0] p, a, v,
                       output logic [7:0] d);
        @(negedge clock_in);
        {page_out, addr_out, wdata_out, wr_out, rd_out} = {p, a, v, w, !w};
        @(negedge clock_in);
        {wr_out, rd_out, wdata_out} = {2'b00, ~v};
        d = rdata_in;
    endtask
    // header first; the code low byte goes last because it starts the run
    task automatic cmd(input logic [15:0] c, input logic [7:0] l, s,
                       input logic bad);
        logic [7:0] k;
        logic [7:0] v [9];
        logic [7:0] d;
        k = ~(c[15:8] + c[7:0] + l + (l != 8'h00 ? s : 8'h00));
        k = k ^ {8{bad}};
        v = '{c[15:8], 8'h00, 8'h00, l, k,
              8'haa, 8'haa, s, c[7:0]};
        for (int i = 0; i < 9; i++) begin
            acc(1'b1, 8'h9f, i == 8 ? 8'h81 : 8'h80 + 8'(i + (i > 0)),
                v[i], d);
        end
    endtask
endmodule
`default_nettype wire

// ---- tb/monitor_histogram_commands_tb.sv ----
// self-checking bench for the command interpreter
`timescale 1ns/1ps
`default_nettype none
module monitor_histogram_commands_tb;
    logic clock_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] page, addr, wdata, rdata, d;
    logic wr, rd, busy;
    logic [31:0] tot, t0;
    logic [7:0] temp = 8'h1e; // module temperature, degC
    int mismatches = 0;
    int compares = 0;
    // free-running clock, 20 ns period
    always #10 clock_in = ~clock_in;
    host_model host (.clock_in(clock_in), .page_out(page), .addr_out(addr),
        .wr_out(wr), .rd_out(rd), .wdata_out(wdata), .rdata_in(rdata));
    // short tick and persist counts keep the run brief
    histo_cmd_top #(.TICK_CYCLES(4), .PERSIST_TICKS(3)) uut (
        .clock_in(clock_in), .rstn_in(rstn_in), .temp_in(temp),
        .mem_page_in(page), .mem_addr_in(addr), .mem_wr_in(wr),
        .mem_rd_in(rd), .mem_wdata_in(wdata), .mem_rdata_out(rdata),
        .busy_out(busy));
    task automatic check(input string n, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic test_done();
        if (mismatches == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // read n bytes, big-endian, into tot
    task automatic get(input logic [7:0] p, a, input int n);
        tot = 32'h0;
        for (int i = 0; i < n; i++) begin
            host.acc(1'b0, p, a + 8'(i), 8'h00, d);
            tot = {tot[23:0], d};
        end
    endtask
    task automatic rd_chk(input logic [7:0] p, a, input int n,
                          input logic [31:0] m, e, input string s);
        get(p, a, n);
        check(s, tot & m, e);
    endtask
    // bounded wait; a hang ends the run as a failure
    task automatic idle();
        @(negedge clock_in);
        for (int i = 0; i < 200 && busy !== 1'b0; i++) @(negedge clock_in);
        if (busy !== 1'b0) begin
            mismatches++;
            test_done();
        end
    endtask
    // run one command, then look at result byte and completion flag
    task automatic run(input logic [15:0] c, input logic [7:0] l, s, e,
                       input logic bad);
        host.cmd(c, l, s, bad);
        idle();
        rd_chk(8'h00, 8'h25, 1, 32'hff, {24'h0, e}, "result");
        rd_chk(8'h00, 8'h08, 1, 32'h40, 32'h40, "done flag");
    endtask
    initial begin
        repeat (12) @(negedge clock_in);
        rstn_in = 1'b1;
        rd_chk(8'h00, 8'h25, 1, 32'hff, 32'h0, "reset result");
        run(16'h0281, 8'h00, 8'h00, 8'h01, 1'b0);
        rd_chk(8'h9f, 8'h86, 2, 32'hffff, 32'h00ff, "reply hdr");
        rd_chk(8'h00, 8'h08, 1, 32'h40, 32'h0, "flag cleared");
        run(16'h0281, 8'h00, 8'h00, 8'h45, 1'b1);
        run(16'h0290, 8'h02, 8'h04, 8'h42, 1'b0);
        run(16'h0282, 8'h00, 8'h00, 8'h42, 1'b0);
        run(16'h0281, 8'h01, 8'h00, 8'h42, 1'b0);
        // return histogram; all time so far spent at 30 degC
        host.cmd(16'h0290, 8'h01, 8'h04, 1'b0);
        repeat (6) @(negedge clock_in);
        rd_chk(8'h00, 8'h25, 1, 32'hff, 32'h83, "busy code");
        idle();
        rd_chk(8'h9f, 8'h86, 1, 32'hff, 32'h34, "reply len");
        rd_chk(8'h9f, 8'h88, 2, 32'hffff, 32'h0401, "echo");
        rd_chk(8'h9f, 8'h90, 4, 32'hffffffff, 32'h0, "low bin");
        get(8'h9f, 8'h8c, 4);
        t0 = tot;
        check("seconds seen", 32'(t0 != 32'h0), 32'h1);
        rd_chk(8'h9f, 8'ha0, 4, 32'hffffffff, t0, "30C bin");
        // go cold first, so every second after the clear is below -5 degC
        temp = 8'hec;
        // clear acts before the snapshot in the same command
        run(16'h0290, 8'h01, 8'h84, 8'h01, 1'b0);
        rd_chk(8'h9f, 8'h8c, 4, 32'hffffffff, 32'h0, "total");
        rd_chk(8'h9f, 8'ha0, 4, 32'hffffffff, 32'h0, "bin");
        run(16'h0290, 8'h01, 8'h02, 8'h01, 1'b0);
        rd_chk(8'h9f, 8'h86, 1, 32'hff, 32'h01, "echo len");
        // cold seconds since the clear land in the lowest bin only
        run(16'h0290, 8'h01, 8'h04, 8'h01, 1'b0);
        get(8'h9f, 8'h8c, 4);
        t0 = tot;
        check("cold seconds", 32'(t0 != 32'h0), 32'h1);
        rd_chk(8'h9f, 8'h90, 4, 32'hffffffff, t0, "cold bin");
        rd_chk(8'h9f, 8'ha0, 4, 32'hffffffff, 32'h0, "warm bin");
        test_done();
    end
endmodule
`default_nettype wire
